// *** pkg/input_sync_pkg.sv ***
package input_sync_pkg;

  // object dictionary subindexes of the input sync group
  localparam logic [7:0] IDX_ENTRY_COUNT = 8'h00;
  localparam logic [7:0] IDX_SYNC_MODE = 8'h01;
  localparam logic [7:0] IDX_CYCLE_TIME = 8'h02;
  localparam logic [7:0] IDX_SHIFT_TIME = 8'h03;
  localparam logic [7:0] IDX_SUPPORTED = 8'h04;
  localparam logic [7:0] IDX_MIN_CYCLE = 8'h05;
  localparam logic [7:0] IDX_CALC_COPY = 8'h06;
  localparam logic [7:0] IDX_MIN_DELAY = 8'h07;
  localparam logic [7:0] IDX_COMMAND = 8'h08;
  localparam logic [7:0] IDX_MAX_DELAY = 8'h09;
  localparam logic [7:0] IDX_MISSED = 8'h0b;
  localparam logic [7:0] IDX_OVERRUN = 8'h0c;
  localparam logic [7:0] IDX_SHORT_SHIFT = 8'h0d;
  localparam logic [7:0] IDX_SYNC_ERROR = 8'h20;

  // values after reset and fixed contents
  localparam logic [7:0] ENTRY_COUNT_VAL = 8'h20;
  localparam logic [15:0] SYNC_MODE_RST = 16'h0022;
  localparam logic [31:0] CYCLE_TIME_RST = 32'h000f4240;
  localparam logic [15:0] SUPPORTED_RST = 16'h0807;
  localparam logic [31:0] MIN_CYCLE_VAL = 32'h000186a0;
  localparam logic [31:0] MIN_DELAY_VAL = 32'h00000000;
  localparam logic [15:0] COMMAND_RST = 16'h0000;

  // supported-modes field layout
  localparam int SUPP_FREE_BIT = 0;
  localparam int SUPP_BM_BIT = 1;
  localparam int SUPP_DC_LSB = 2;
  localparam int SUPP_SHIFT_LSB = 4;
  localparam int SUPP_DYN_BIT = 14;
  localparam logic [1:0] SUPP_DC_PATTERN = 2'h1;
  localparam logic [1:0] SHIFT_LOCAL_EVENT = 2'h1;
  localparam logic [1:0] SHIFT_SECOND_PULSE = 2'h2;

  // buffer-manager channel numbers
  localparam logic [2:0] OUTPUT_BM_CHANNEL = 3'h3;
  localparam logic [2:0] INPUT_BM_CHANNEL = 3'h4;

  // timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam logic [31:0] CLK_PERIOD_NS = 32'(1000 / CLK_FREQ_MHZ);
  localparam logic [31:0] SYNC_GAP_MIN_NS = 32'h000003e8;

  typedef enum logic [15:0] {
    MODE_FREE_RUN = 16'h0000,
    MODE_INPUT_BM = 16'h0001,
    MODE_FIRST_PULSE = 16'h0002,
    MODE_SECOND_PULSE = 16'h0003,
    MODE_OUTPUT_BM = 16'h0022
  } sync_mode_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] subidx;
    logic [31:0] wdata;
  } od_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } od_rsp_t;

endpackage

// *** rtl/input_sync_parameter_monitor.sv ***
// Functional notes
// - mode codes 0,1,2,3,34 select sampling
// - free run: cycle time is local timer period
// - cycle time holds the value the master wrote
// - shift time: first pulse to sampling
// - supported bits 0,1 set, bits 2-3 01
// - bits 4-5 shift kind, bit 14 dynamic
// - minimum cycle time reads fixed value
// - calc-copy: sampling to inputs available
// - command 1 starts, 0 stops measurement
// - measuring keeps largest observed times
// - new measurement clears stored maxima
// - max delay: second pulse to sampling
// - count missed input events in run state
// - count late or early cycles in run
// - count too short pulse intervals
// - sync error flags faulty previous cycle
// - group header reports 0x20 entries
// - input buffer manager is channel four
`timescale 1ns/1ns
`default_nettype none

module input_sync_parameter_monitor #(
  parameter logic [1:0] INPUT_SHIFT_KIND = 2'h0,
  parameter logic DYNAMIC_TIMES = 1'b0,
  parameter logic [31:0] SYNC_GAP_MIN_NS = input_sync_pkg::SYNC_GAP_MIN_NS
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire input_sync_pkg::od_req_t od_req_in,
  output input_sync_pkg::od_rsp_t od_rsp_out,
  input wire logic run_state_in,
  input wire logic bm_event_in,
  input wire logic [2:0] bm_channel_in,
  input wire logic first_cyclic_sync_pulse_in,
  input wire logic second_cyclic_sync_pulse_in,
  input wire logic inputs_ready_in,
  output logic sample_trigger_out,
  output logic sync_error_out
);

  function automatic logic [31:0] ns_add(input logic [31:0] t);
    logic [32:0] s;
    s = {1'b0, t} + {1'b0, input_sync_pkg::CLK_PERIOD_NS};
    ns_add = s[32] ? 32'hffffffff : s[31:0];
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] c, input logic hit);
    sat_inc = (hit && c != 16'hffff) ? c + 16'h0001 : c;
  endfunction

  function automatic logic [31:0] keep_max(input logic [31:0] cur, input logic [31:0] obs);
    keep_max = (obs > cur) ? obs : cur;
  endfunction

  logic [15:0] mode_ff;
  logic [31:0] cycle_time_ff;
  logic [15:0] command_ff;
  logic measuring_ff;
  logic [31:0] shift_max_ff;
  logic [31:0] calc_max_ff;
  logic [31:0] delay_max_ff;
  logic [15:0] missed_ff;
  logic [15:0] overrun_ff;
  logic [15:0] short_ff;
  logic sync_err_ff;
  logic [31:0] fr_ns_ff;
  logic [31:0] since0_ff;
  logic [31:0] since1_ff;
  logic [31:0] since_trig_ff;
  logic busy_ff;
  logic late_noted_ff;
  logic seen0_ff;
  logic seen1_ff;
  logic in_read_ff;
  logic trig_ff;
  input_sync_pkg::od_rsp_t rsp_ff;

  // request decode
  wire logic req_wr = od_req_in.valid & od_req_in.wr;
  wire logic [7:0] sub = od_req_in.subidx;
  wire logic [31:0] wd = od_req_in.wdata;
  wire logic wr_mode = req_wr && sub == input_sync_pkg::IDX_SYNC_MODE;
  wire logic wr_cycle = req_wr && sub == input_sync_pkg::IDX_CYCLE_TIME;
  wire logic wr_cmd = req_wr && sub == input_sync_pkg::IDX_COMMAND;
  wire logic mode_legal = wd[31:16] == 16'h0000 &&
    (wd[15:0] == input_sync_pkg::MODE_FREE_RUN ||
     wd[15:0] == input_sync_pkg::MODE_INPUT_BM ||
     wd[15:0] == input_sync_pkg::MODE_FIRST_PULSE ||
     wd[15:0] == input_sync_pkg::MODE_SECOND_PULSE ||
     wd[15:0] == input_sync_pkg::MODE_OUTPUT_BM);
  // a period below the floor could never be met, so it is refused
  wire logic cycle_legal = wd >= input_sync_pkg::MIN_CYCLE_VAL;
  wire logic cmd_legal = wd[31:1] == 31'h0;
  wire logic do_mode = wr_mode & mode_legal;
  wire logic do_cycle = wr_cycle & cycle_legal;
  wire logic do_cmd = wr_cmd & cmd_legal;
  wire logic meas_start = do_cmd & wd[0];
  wire logic meas_stop = do_cmd & ~wd[0];

  // mode decode
  wire logic m_free = mode_ff == input_sync_pkg::MODE_FREE_RUN;
  wire logic m_in_bm = mode_ff == input_sync_pkg::MODE_INPUT_BM;
  wire logic m_dc0 = mode_ff == input_sync_pkg::MODE_FIRST_PULSE;
  wire logic m_dc1 = mode_ff == input_sync_pkg::MODE_SECOND_PULSE;
  wire logic m_out_bm = mode_ff == input_sync_pkg::MODE_OUTPUT_BM;
  wire logic m_dc = m_dc0 | m_dc1;

  // buffer-manager events by channel
  wire logic in_bm_evt = bm_event_in && bm_channel_in == input_sync_pkg::INPUT_BM_CHANNEL;
  wire logic out_bm_evt = bm_event_in && bm_channel_in == input_sync_pkg::OUTPUT_BM_CHANNEL;
  wire logic p0 = first_cyclic_sync_pulse_in;
  wire logic p1 = second_cyclic_sync_pulse_in;

  // free-running local timer, period taken from the cycle time in ns
  wire logic [32:0] fr_next_sum = {1'b0, fr_ns_ff} + {1'b0, input_sync_pkg::CLK_PERIOD_NS};
  wire logic fr_fire = m_free && fr_next_sum >= {1'b0, cycle_time_ff};
  wire logic [31:0] nxt_fr_ns = (!m_free || fr_fire) ? 32'h0 : fr_next_sum[31:0];

  // sampling moment per mode
  wire logic trig = (m_free & fr_fire) | (m_in_bm & in_bm_evt) |
    (m_dc0 & p0) | (m_dc1 & p1) | (m_out_bm & out_bm_evt);

  // elapsed times; an event in this cycle counts as zero distance
  wire logic [31:0] at0 = p0 ? 32'h0 : since0_ff;
  wire logic [31:0] at1 = p1 ? 32'h0 : since1_ff;
  // the registers are seen one cycle after the event, so they restart at one period
  wire logic [31:0] nxt_since0 = p0 ? input_sync_pkg::CLK_PERIOD_NS : ns_add(since0_ff);
  wire logic [31:0] nxt_since1 = p1 ? input_sync_pkg::CLK_PERIOD_NS : ns_add(since1_ff);
  wire logic [31:0] nxt_since_trig = trig ? input_sync_pkg::CLK_PERIOD_NS : ns_add(since_trig_ff);

  // measurement captures, only meaningful in shared-time mode
  wire logic cap_trig = measuring_ff & m_dc & trig;
  wire logic cap_ready = measuring_ff & m_dc & busy_ff & inputs_ready_in;
  wire logic [31:0] nxt_shift = meas_start ? 32'h0 :
    cap_trig && seen0_ff ? keep_max(shift_max_ff, at0) : shift_max_ff;
  wire logic [31:0] nxt_delay = meas_start ? 32'h0 :
    cap_trig && seen1_ff ? keep_max(delay_max_ff, at1) : delay_max_ff;
  wire logic [31:0] nxt_calc = meas_start ? 32'h0 :
    cap_ready ? keep_max(calc_max_ff, since_trig_ff) : calc_max_ff;

  // cycle completion tracking; a new sample wins over an old completion
  wire logic nxt_busy = trig | (busy_ff & ~inputs_ready_in);
  wire logic late = busy_ff && !late_noted_ff && !inputs_ready_in &&
    since_trig_ff >= cycle_time_ff;
  wire logic early = trig && busy_ff && !inputs_ready_in && !late_noted_ff;
  wire logic nxt_late_noted = ~trig & (late_noted_ff | late);
  wire logic overrun_hit = run_state_in & (late | early);

  // missed input events: a pulse period passed with no master read
  wire logic nxt_in_read = in_bm_evt | (in_read_ff & ~p0);
  wire logic missed_hit = m_dc && run_state_in && p0 && seen0_ff &&
    !in_read_ff && !in_bm_evt;

  // second pulse too close behind the first
  wire logic short_hit = m_dc && p1 && seen0_ff && at0 < SYNC_GAP_MIN_NS;

  // error of the cycle just closed, judged at each first pulse
  wire logic nxt_sync_err = !m_dc ? 1'b0 :
    p0 ? (seen0_ff && (busy_ff && !inputs_ready_in || missed_hit)) : sync_err_ff;

  // supported-modes word
  wire logic [15:0] supp_mask = 16'h0001 << input_sync_pkg::SUPP_FREE_BIT |
    16'h0001 << input_sync_pkg::SUPP_BM_BIT |
    16'h0003 << input_sync_pkg::SUPP_DC_LSB |
    16'h0003 << input_sync_pkg::SUPP_SHIFT_LSB |
    16'h0001 << input_sync_pkg::SUPP_DYN_BIT;
  wire logic [15:0] supp_val = (input_sync_pkg::SUPPORTED_RST & ~supp_mask) |
    16'h0001 << input_sync_pkg::SUPP_FREE_BIT |
    16'h0001 << input_sync_pkg::SUPP_BM_BIT |
    {14'h0, input_sync_pkg::SUPP_DC_PATTERN} << input_sync_pkg::SUPP_DC_LSB |
    {14'h0, INPUT_SHIFT_KIND} << input_sync_pkg::SUPP_SHIFT_LSB |
    {15'h0, DYNAMIC_TIMES} << input_sync_pkg::SUPP_DYN_BIT;

  // read selection and refusal
  logic [31:0] rd_val;
  logic rd_hit;
  logic ro_hit;
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    ro_hit = 1'b1;
    unique case (sub)
      input_sync_pkg::IDX_ENTRY_COUNT: rd_val = {24'h0, input_sync_pkg::ENTRY_COUNT_VAL};
      input_sync_pkg::IDX_SYNC_MODE: begin
        rd_val = {16'h0, mode_ff};
        ro_hit = 1'b0;
      end
      input_sync_pkg::IDX_CYCLE_TIME: begin
        rd_val = cycle_time_ff;
        ro_hit = 1'b0;
      end
      input_sync_pkg::IDX_SHIFT_TIME: rd_val = shift_max_ff;
      input_sync_pkg::IDX_SUPPORTED: rd_val = {16'h0, supp_val};
      input_sync_pkg::IDX_MIN_CYCLE: rd_val = input_sync_pkg::MIN_CYCLE_VAL;
      input_sync_pkg::IDX_CALC_COPY: rd_val = calc_max_ff;
      input_sync_pkg::IDX_MIN_DELAY: rd_val = input_sync_pkg::MIN_DELAY_VAL;
      input_sync_pkg::IDX_COMMAND: begin
        rd_val = {16'h0, command_ff};
        ro_hit = 1'b0;
      end
      input_sync_pkg::IDX_MAX_DELAY: rd_val = delay_max_ff;
      input_sync_pkg::IDX_MISSED: rd_val = {16'h0, missed_ff};
      input_sync_pkg::IDX_OVERRUN: rd_val = {16'h0, overrun_ff};
      input_sync_pkg::IDX_SHORT_SHIFT: rd_val = {16'h0, short_ff};
      input_sync_pkg::IDX_SYNC_ERROR: rd_val = {31'h0, sync_err_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  wire logic bad_val = (wr_mode & ~mode_legal) | (wr_cycle & ~cycle_legal) | (wr_cmd & ~cmd_legal);
  wire logic req_err = !rd_hit || (od_req_in.wr && (ro_hit || bad_val));
  wire input_sync_pkg::od_rsp_t nxt_rsp = '{
    ack: od_req_in.valid,
    err: od_req_in.valid & req_err,
    rdata: (od_req_in.valid & ~od_req_in.wr & rd_hit) ? rd_val : 32'h0
  };

  // parameters written by the master
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode_ff <= input_sync_pkg::SYNC_MODE_RST;
      cycle_time_ff <= input_sync_pkg::CYCLE_TIME_RST;
      command_ff <= input_sync_pkg::COMMAND_RST;
      measuring_ff <= 1'b0;
    end else begin
      if (do_mode) begin
        mode_ff <= wd[15:0];
      end
      if (do_cycle) begin
        cycle_time_ff <= wd;
      end
      if (do_cmd) begin
        command_ff <= wd[15:0];
      end
      measuring_ff <= meas_start | (measuring_ff & ~meas_stop);
    end
  end

  // measured maxima
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      shift_max_ff <= 32'h0;
      calc_max_ff <= 32'h0;
      delay_max_ff <= 32'h0;
    end else begin
      shift_max_ff <= nxt_shift;
      calc_max_ff <= nxt_calc;
      delay_max_ff <= nxt_delay;
    end
  end

  // event counters and error flag
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      missed_ff <= 16'h0;
      overrun_ff <= 16'h0;
      short_ff <= 16'h0;
      sync_err_ff <= 1'b0;
    end else begin
      missed_ff <= sat_inc(missed_ff, missed_hit);
      overrun_ff <= sat_inc(overrun_ff, overrun_hit);
      short_ff <= sat_inc(short_ff, short_hit);
      sync_err_ff <= nxt_sync_err;
    end
  end

  // timers and cycle tracking
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      fr_ns_ff <= 32'h0;
      since0_ff <= 32'h0;
      since1_ff <= 32'h0;
      since_trig_ff <= 32'h0;
      busy_ff <= 1'b0;
      late_noted_ff <= 1'b0;
      seen0_ff <= 1'b0;
      seen1_ff <= 1'b0;
      in_read_ff <= 1'b0;
      trig_ff <= 1'b0;
    end else begin
      fr_ns_ff <= nxt_fr_ns;
      since0_ff <= nxt_since0;
      since1_ff <= nxt_since1;
      since_trig_ff <= nxt_since_trig;
      busy_ff <= nxt_busy;
      late_noted_ff <= nxt_late_noted;
      seen0_ff <= seen0_ff | p0;
      seen1_ff <= seen1_ff | p1;
      in_read_ff <= nxt_in_read;
      trig_ff <= trig;
    end
  end

  // response port
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign od_rsp_out = rsp_ff;
  assign sample_trigger_out = trig_ff;
  assign sync_error_out = sync_err_ff;

endmodule

`default_nettype wire

// *** verification/input_sync_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module input_sync_props (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire input_sync_pkg::od_req_t od_req_in,
  input wire input_sync_pkg::od_rsp_t od_rsp_out,
  input wire logic first_cyclic_sync_pulse_in,
  input wire logic sync_error_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  wire logic rdq = od_req_in.valid && !od_req_in.wr;
  wire logic wrq = od_req_in.valid && od_req_in.wr;
  wire logic [7:0] ix = od_req_in.subidx;
  wire logic [31:0] wd = od_req_in.wdata;
  chk_header_value: assert property (rdq && ix == 8'h00 |=> od_rsp_out.rdata == 32'h00000020)
    else $error("header count wrong");
  chk_supported_value: assert property (rdq && ix == 8'h04 |=> od_rsp_out.rdata == 32'h00000807)
    else $error("supported modes wrong");
  chk_min_cycle: assert property (rdq && ix == 8'h05 |=> od_rsp_out.rdata == 32'h000186a0)
    else $error("minimum cycle wrong");
  chk_ro_refused: assert property (wrq && ix inside {8'h03, 8'h04, 8'h05} |=> od_rsp_out.err)
    else $error("read-only write accepted");
  chk_mode_refused: assert property (wrq && ix == 8'h01 && !(wd inside {32'h0, 32'h1, 32'h2, 32'h3, 32'h22})
    |=> od_rsp_out.ack && od_rsp_out.err) else $error("bad mode accepted");
  chk_cmd_refused: assert property (wrq && ix == 8'h08 && wd > 32'h1 |=> od_rsp_out.err)
    else $error("bad command accepted");
  chk_cycle_refused: assert property (wrq && ix == 8'h02 && wd < 32'h000186a0 |=> od_rsp_out.err)
    else $error("short cycle accepted");
  chk_error_at_pulse: assert property ($rose(sync_error_out) |-> $past(first_cyclic_sync_pulse_in))
    else $error("sync error set off pulse");
endmodule
bind input_sync_parameter_monitor input_sync_props input_sync_props_i (
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .od_req_in(od_req_in),
  .od_rsp_out(od_rsp_out),
  .first_cyclic_sync_pulse_in(first_cyclic_sync_pulse_in),
  .sync_error_out(sync_error_out)
);
`default_nettype wire

// *** verification/sync_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sync_master_model (
  input wire logic clk_sys_in,
  input wire logic run_in,
  input wire logic [7:0] gap_in,
  input wire logic drop_read_in,
  input wire logic drop_ready_in,
  output logic first_out,
  output logic second_out,
  output logic bm_event_out,
  output logic [2:0] bm_channel_out,
  output logic ready_out
);
  // 100 cycle period; gap must stay below 0x50 so every event fits
  logic [7:0] cnt_ff;
  always_ff @(posedge clk_sys_in) begin
    cnt_ff <= (!run_in || cnt_ff == 8'h63) ? 8'h00 : cnt_ff + 8'h01;
  end
  assign first_out = run_in && cnt_ff == 8'h00;
  assign second_out = run_in && cnt_ff == gap_in;
  // master reads the input buffer; drop skips it
  assign bm_event_out = run_in && !drop_read_in && cnt_ff == gap_in + 8'h14;
  // idle shows another channel so a stale four cannot pass
  assign bm_channel_out = bm_event_out ? 3'h4 : 3'h3;
  assign ready_out = run_in && !drop_ready_in && cnt_ff == gap_in + 8'h05;
endmodule
`default_nettype wire

// *** verification/input_sync_parameter_monitor_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module input_sync_parameter_monitor_tb;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic run_state = 1'b0;
  logic run = 1'b0;
  logic drop_rd = 1'b0;
  logic drop_rdy = 1'b0;
  logic [7:0] gap = 8'h46;
  input_sync_pkg::od_req_t req = '0;
  input_sync_pkg::od_rsp_t rsp;
  logic first, second, bm_ev, rdy, trig, serr;
  logic [2:0] bm_ch;
  int err_total = 0;
  int tests_run = 0;
  int trig_cnt = 0;
  localparam logic [7:0] DIX [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20};
  localparam logic [31:0] DVAL [14] = '{32'h20, 32'h22, 32'h000f4240, 32'h0, 32'h0807, 32'h000186a0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [7:0] BIX [5] = '{8'h01, 8'h02, 8'h08, 8'h03, 8'h0a};
  localparam logic [31:0] BVAL [5] = '{32'h4, 32'h0001869f, 32'h2, 32'h5, 32'h0};
  localparam logic [31:0] MODES [4] = '{32'h1, 32'h2, 32'h3, 32'h22};
  localparam logic [31:0] NTRIG [4] = '{32'h2, 32'h2, 32'h2, 32'h0};
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (trig === 1'b1) trig_cnt++;
  input_sync_parameter_monitor #(.SYNC_GAP_MIN_NS(32'h00000258)) input_sync_parameter_monitor_i (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .od_req_in(req), .od_rsp_out(rsp),
    .run_state_in(run_state), .bm_event_in(bm_ev), .bm_channel_in(bm_ch),
    .first_cyclic_sync_pulse_in(first), .second_cyclic_sync_pulse_in(second),
    .inputs_ready_in(rdy), .sample_trigger_out(trig), .sync_error_out(serr));
  sync_master_model sync_master_model_i (.clk_sys_in(clk_sys_in), .run_in(run), .gap_in(gap),
    .drop_read_in(drop_rd), .drop_ready_in(drop_rdy), .first_out(first), .second_out(second),
    .bm_event_out(bm_ev), .bm_channel_out(bm_ch), .ready_out(rdy));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic od(input logic w, input logic [7:0] ix, input logic [31:0] d, output logic [31:0] q,
      output logic e);
    req <= '{valid: 1'b1, wr: w, subidx: ix, wdata: d};
    @(posedge clk_sys_in);
    req <= '0;
    // the answer stands only in the cycle right after the request edge
    @(posedge clk_sys_in);
    q = rsp.rdata;
    e = rsp.err;
    chk("response ack", {31'h0, rsp.ack}, 32'h1);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    od(1'b0, ix, 32'h0, q, e);
    chk($sformatf("subindex %h", ix), q, x);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic x);
    logic [31:0] q;
    logic e;
    od(1'b1, ix, d, q, e);
    chk($sformatf("error of write %h", ix), {31'h0, e}, {31'h0, x});
  endtask
  task automatic burst(input int n, input logic [7:0] g, input logic dr, input logic dy);
    gap <= g;
    drop_rd <= dr;
    drop_rdy <= dy;
    run <= 1'b1;
    repeat (n * 100) @(posedge clk_sys_in);
    run <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic defaults();
    for (int i = 0; i < 14; i++) rd(DIX[i], DVAL[i]);
  endtask
  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    err_total++;
    report_and_stop();
  end
  initial begin
    int n;
    int c;
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    defaults();
    tend("defaults");
    for (int i = 0; i < 5; i++) wr(BIX[i], BVAL[i], 1'b1);
    defaults();
    tend("refused");
    wr(8'h01, 32'h0, 1'b0);
    wr(8'h02, 32'h000186a0, 1'b0);
    n = 0;
    while (trig !== 1'b1 && n < 20000) begin
      @(posedge clk_sys_in);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (trig !== 1'b1 && n < 20000);
    chk("free run period", 32'(n), 32'h00002710);
    tend("free run");
    // only the channel four event may trigger mode one
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, MODES[i], 1'b0);
      rd(8'h01, MODES[i]);
      c = trig_cnt;
      burst(2, 8'h46, 1'b0, 1'b0);
      chk("trigger count", 32'(trig_cnt - c), NTRIG[i]);
    end
    wr(8'h01, 32'h3, 1'b0);
    tend("modes");
    run_state <= 1'b1;
    wr(8'h08, 32'h1, 1'b0);
    burst(3, 8'h32, 1'b0, 1'b0);
    rd(8'h03, 32'h000001f4);
    rd(8'h06, 32'h00000032);
    rd(8'h09, 32'h0);
    rd(8'h0d, 32'h3);
    wr(8'h08, 32'h1, 1'b0);
    rd(8'h03, 32'h0);
    wr(8'h08, 32'h0, 1'b0);
    burst(1, 8'h3c, 1'b0, 1'b0);
    rd(8'h03, 32'h0);
    rd(8'h0d, 32'h3);
    tend("measure");
    burst(3, 8'h46, 1'b0, 1'b1);
    rd(8'h20, 32'h1);
    chk("sync error pin", {31'h0, serr}, 32'h1);
    burst(2, 8'h46, 1'b0, 1'b0);
    rd(8'h0c, 32'h3);
    rd(8'h20, 32'h0);
    chk("sync error pin", {31'h0, serr}, 32'h0);
    burst(3, 8'h46, 1'b1, 1'b0);
    burst(1, 8'h46, 1'b0, 1'b0);
    rd(8'h0b, 32'h3);
    tend("faults");
    rstn_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(8'h0b, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h01, 32'h22);
    tend("reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
